//--- logic/pfr_sequencer.sv
// Device-side serial programming sequencer for program flash erase and rewrite.
`timescale 1ns/1ps
module pfr_sequencer
  import pfr_pkg::*;
#(
  parameter int unsigned WBUF = WBUF_BYTES,
  parameter int unsigned EBLK = ERASE_BYTES
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               programming_clock,
  input  wire logic               prog_data_in,
  output logic                    prog_data_out,
  output logic                    prog_data_oe,
  output logic                    write_enable_bit,
  output logic                    write_busy,
  output logic                    erase_req,
  output logic [PTR_W-1:0]        erase_addr,
  input  wire logic               erase_done,
  output logic                    prog_active,
  output logic                    flash_wvalid,
  output logic [PTR_W+7:0]        flash_wdata,
  input  wire logic               flash_wready
);
  localparam int unsigned IW = $clog2(WBUF);
  localparam int unsigned EW = $clog2(EBLK);

  typedef struct packed {
    logic                   clk_s1;
    logic                   clk_s2;
    logic                   clk_q;
    logic                   dat_s1;
    logic                   dat_s2;
    pfr_phase_e             phase;
    logic [4:0]             cnt;
    logic [3:0]             cmd;
    logic [15:0]            sh;
    logic [7:0]             wreg;
    logic [7:0]             fctrl;
    logic [PTR_W-1:0]       tp;
    logic [7:0]             tlat;
    logic [WBUF-1:0][7:0]   wbuf;
    logic [1:0]             nops;
    logic                   ereq;
    logic [PTR_W-1:0]       eaddr;
    logic                   prog_pend;
    logic                   prog_act;
    logic                   draining;
    logic [IW:0]            didx;
    logic [PTR_W-1:0]       dbase;
    logic                   dout;
    logic                   doe;
  } pfr_seq_s;

  pfr_seq_s st_r;
  pfr_seq_s st_nxt;

  logic                fifo_in_valid;
  logic [PTR_W+7:0]    fifo_in_data;
  logic                fifo_in_ready;

  // Buffer slot of a pointer value: only the low address bits matter.
  function automatic logic [IW-1:0] wb_index(input logic [PTR_W-1:0] p);
    return p[IW-1:0];
  endfunction

  // ***************************************************************
  // Buffer drain toward the flash array
  // ***************************************************************
  // The drain stalls on a full FIFO; programming does not wait for it, so a slow array only delays the drain.
  assign fifo_in_valid = st_r.draining;
  assign fifo_in_data  = {st_r.dbase | PTR_W'(st_r.didx[IW-1:0]),
                          st_r.wbuf[st_r.didx[IW-1:0]]};

  pfr_fifo #(
    .WIDTH (PTR_W + 8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (flash_wvalid),
    .out_data  (flash_wdata),
    .out_ready (flash_wready)
  );

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    logic        rise;
    logic        fall;
    logic [15:0] pl;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic        wr_f;
    logic [7:0]  wval;
    rise   = 1'b0;
    fall   = 1'b0;
    pl     = '0;
    hi     = '0;
    lo     = '0;
    wr_f   = 1'b0;
    wval   = '0;
    st_nxt = st_r;
    // Pins pass two flops; edge detection compares the second clock flop with a third one.
    st_nxt.clk_s1 = programming_clock;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.clk_q  = st_r.clk_s2;
    st_nxt.dat_s1 = prog_data_in;
    st_nxt.dat_s2 = st_r.dat_s1;
    rise = st_r.clk_s2 && !st_r.clk_q;
    fall = !st_r.clk_s2 && st_r.clk_q;
    pl   = {st_r.dat_s2, st_r.sh[15:1]};
    hi   = pl[15:8];
    lo   = pl[7:0];

    // Fourth command clock: erase or programming may begin here.
    if (rise && st_r.phase == PH_CMD && st_r.cnt == CMD_LAST &&
        {st_r.dat_s2, st_r.cmd[3:1]} == CMD_CORE) begin
      // A row erase starts here only with row-erase set; write-start without row-erase stays pending.
      if (st_r.fctrl[FC_WR] && st_r.fctrl[FC_WRITE_EN] && st_r.fctrl[FC_ROW_ERASE] &&
          st_r.nops == 2'd1 && !st_r.ereq) begin
        st_nxt.ereq  = 1'b1;
        st_nxt.eaddr = {st_r.tp[PTR_W-1:EW], EW'(0)};
      end
      if (st_r.prog_pend) begin
        st_nxt.prog_act  = 1'b1;
        st_nxt.prog_pend = 1'b0;
        st_nxt.draining  = 1'b1;
        st_nxt.didx      = '0;
        st_nxt.dbase     = {st_r.tp[PTR_W-1:IW], IW'(0)};
      end
    end

    // Programming ends as soon as the held clock is brought low.
    if (fall && st_r.prog_act) begin
      st_nxt.prog_act = 1'b0;
    end

    // Table latch bits leave on rising edges; the programmer samples on falls.
    if (rise && st_r.phase == PH_DATA && st_r.cmd == CMD_SHIFT_OUT &&
        st_r.cnt >= SHOUT_FIRST) begin
      st_nxt.dout = st_r.tlat[st_r.cnt[2:0]];
      st_nxt.doe  = 1'b1;
    end

    // Bits are taken on falling edges, least significant first.
    if (fall) begin
      st_nxt.cnt = st_r.cnt + 5'd1;
      if (st_r.phase == PH_CMD) begin
        st_nxt.cmd = {st_r.dat_s2, st_r.cmd[3:1]};
        if (st_r.cnt == CMD_LAST) begin
          st_nxt.phase = PH_DATA;
          st_nxt.cnt   = '0;
        end
      end else begin
        st_nxt.sh = pl;
        if (st_r.cnt == PAYLOAD_LAST) begin
          st_nxt.phase = PH_CMD;
          st_nxt.cnt   = '0;
          st_nxt.doe   = 1'b0;
          unique case (st_r.cmd)
            CMD_CORE: begin
              // Any instruction other than a no-operation resets the count.
              if (pl == OP_NOP) begin
                if (st_r.fctrl[FC_WR] && st_r.nops != 2'd2) begin
                  st_nxt.nops = st_r.nops + 2'd1;
                end
              end else begin
                st_nxt.nops = '0;
              end
              if (hi == OP_MOVLW) begin
                st_nxt.wreg = lo;
              end else if (hi == OP_MOVF && lo == ADDR_FCTRL) begin
                st_nxt.wreg = st_r.fctrl;
              end else if (hi == OP_MOVWF || hi == OP_CLRF) begin
                wr_f = 1'b1;
                wval = (hi == OP_MOVWF) ? st_r.wreg : 8'h00;
              end else if ((hi[7:4] == OP_BSF_HI || hi[7:4] == OP_BCF_HI) &&
                           hi[0] == 1'b0 && lo == ADDR_FCTRL) begin
                if (hi[7:4] == OP_BCF_HI) begin
                  // Write-start is cleared only by hardware at erase completion.
                  if (hi[3:1] != 3'(FC_WR)) begin
                    st_nxt.fctrl[hi[3:1]] = 1'b0;
                  end
                end else if (hi[3:1] != 3'(FC_WR) || st_r.fctrl[FC_WRITE_EN]) begin
                  st_nxt.fctrl[hi[3:1]] = 1'b1;
                  if (hi[3:1] == 3'(FC_WR) && !st_r.fctrl[FC_WR]) begin
                    st_nxt.nops = '0;
                  end
                end
              end
              if (wr_f) begin
                unique case (lo)
                  ADDR_PTR_UP: st_nxt.tp[PTR_W-1:16] = wval[PTR_W-17:0];
                  ADDR_PTR_HI: st_nxt.tp[15:8]       = wval;
                  ADDR_PTR_LO: st_nxt.tp[7:0]        = wval;
                  ADDR_TLAT:   st_nxt.tlat           = wval;
                  ADDR_FCTRL:  st_nxt.fctrl          = {wval[7:2],
                                 st_r.fctrl[FC_WR] | (wval[FC_WR] & st_r.fctrl[FC_WRITE_EN]),
                                 wval[0]};
                  default: ;
                endcase
              end
            end
            CMD_LOAD_INC2, CMD_LOAD_PROG: begin
              // Low byte to the even slot, high byte to the next one.
              st_nxt.wbuf[wb_index(st_r.tp)]                  = lo;
              st_nxt.wbuf[wb_index(st_r.tp + PTR_W'(1))]      = hi;
              if (st_r.cmd == CMD_LOAD_INC2) begin
                st_nxt.tp = st_r.tp + PTR_INC;
              end else begin
                st_nxt.prog_pend = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
    end

    // Erase completion clears write-start; software cannot clear it meanwhile.
    if (st_r.ereq && erase_done) begin
      st_nxt.ereq          = 1'b0;
      st_nxt.fctrl[FC_WR]  = 1'b0;
      st_nxt.nops          = '0;
    end

    // Drain the buffer, then refill it with erased bytes for the next row.
    if (st_r.draining && fifo_in_ready) begin
      st_nxt.didx = st_r.didx + (IW+1)'(1);
      if (st_r.didx == (IW+1)'(WBUF - 1)) begin
        st_nxt.draining = 1'b0;
        st_nxt.wbuf     = {WBUF{ERASED_BYTE}};
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r       <= '0;
      st_r.phase <= PH_CMD;
      st_r.fctrl <= FCTRL_RESET;
      st_r.wbuf  <= {WBUF{ERASED_BYTE}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign prog_data_out    = st_r.dout;
  assign prog_data_oe     = st_r.doe;
  assign write_enable_bit = st_r.fctrl[FC_WRITE_EN];
  assign write_busy       = st_r.fctrl[FC_WR];
  assign erase_req        = st_r.ereq;
  assign erase_addr       = st_r.eaddr;
  assign prog_active      = st_r.prog_act;
endmodule

//--- logic/pfr_pkg.sv
// Package of constants and types for the program flash row modify sequencer.
package pfr_pkg;

  // ***************************************************************
  // Link framing
  // ***************************************************************
  localparam int unsigned CMD_BITS      = 4;
  localparam int unsigned PAYLOAD_BITS  = 16;
  localparam logic [4:0]  CMD_LAST      = 5'h03;
  localparam logic [4:0]  PAYLOAD_LAST  = 5'h0F;
  localparam logic [4:0]  SHOUT_FIRST   = 5'h08;

  // ***************************************************************
  // Four-bit commands
  // ***************************************************************
  localparam logic [3:0] CMD_CORE      = 4'h0;
  localparam logic [3:0] CMD_SHIFT_OUT = 4'h2;
  localparam logic [3:0] CMD_LOAD_INC2 = 4'hD;
  localparam logic [3:0] CMD_LOAD_PROG = 4'hF;

  // ***************************************************************
  // Core instruction opcodes and register addresses
  // ***************************************************************
  localparam logic [7:0] OP_MOVLW      = 8'h0E;
  localparam logic [7:0] OP_MOVWF      = 8'h6E;
  localparam logic [7:0] OP_CLRF       = 8'h6A;
  localparam logic [7:0] OP_MOVF       = 8'h50;
  localparam logic [3:0] OP_BSF_HI     = 4'h8;
  localparam logic [3:0] OP_BCF_HI     = 4'h9;
  localparam logic [15:0] OP_NOP       = 16'h0000;
  localparam logic [7:0] ADDR_PTR_UP   = 8'hF8;
  localparam logic [7:0] ADDR_PTR_HI   = 8'hF7;
  localparam logic [7:0] ADDR_PTR_LO   = 8'hF6;
  localparam logic [7:0] ADDR_TLAT     = 8'hF5;
  localparam logic [7:0] ADDR_FCTRL    = 8'hA6;

  // ***************************************************************
  // Flash control register fields and reset values
  // ***************************************************************
  localparam int unsigned FC_PGM_SEL   = 7;
  localparam int unsigned FC_CFG_SEL   = 6;
  localparam int unsigned FC_ROW_ERASE = 4;
  localparam int unsigned FC_WRITE_EN  = 2;
  localparam int unsigned FC_WR        = 1;
  localparam logic [7:0]  FCTRL_RESET  = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int unsigned PTR_W        = 22;
  localparam logic [21:0] PTR_INC      = 22'h000002;
  localparam int unsigned WBUF_BYTES   = 16;
  localparam int unsigned ERASE_BYTES  = 64;
  localparam int unsigned FIFO_DEPTH   = 16;

  // Link decoder phase.
  typedef enum logic {PH_CMD, PH_DATA} pfr_phase_e;

endpackage

//--- logic/pfr_fifo.sv
// Synchronous FIFO that carries programmed bytes toward the flash array.
`timescale 1ns/1ps
module pfr_fifo
  import pfr_pkg::*;
#(
  parameter int unsigned WIDTH = 30,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 count;
    logic                        vld;
  } pfr_fifo_s;

  pfr_fifo_s st_r;
  pfr_fifo_s st_nxt;

  // Full comes from the count; valid is its own flop so the array sees a clean level.
  assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid = st_r.vld;
  assign out_data  = st_r.mem[st_r.rp];

  // Push and pop may happen together; the count then stays put.
  always_comb begin
    logic push;
    logic pop;
    push   = 1'b0;
    pop    = 1'b0;
    st_nxt = st_r;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    st_nxt.vld   = (st_nxt.count != '0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- sim/pfr_sequencer_sva.sv
// Concurrent checks on the ports of the program flash row modify sequencer.
`timescale 1ns/1ps
module pfr_sequencer_sva
  import pfr_pkg::*;
#(
  parameter int unsigned WBUF = WBUF_BYTES,
  parameter int unsigned EBLK = ERASE_BYTES
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             ce,
  input wire logic             programming_clock,
  input wire logic             prog_data_in,
  input wire logic             prog_data_out,
  input wire logic             prog_data_oe,
  input wire logic             write_enable_bit,
  input wire logic             write_busy,
  input wire logic             erase_req,
  input wire logic [PTR_W-1:0] erase_addr,
  input wire logic             erase_done,
  input wire logic             prog_active,
  input wire logic             flash_wvalid,
  input wire logic [PTR_W+7:0] flash_wdata,
  input wire logic             flash_wready
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ***************************************************************
  // Erase, programming and read-back relations
  // ***************************************************************
  // A cycle without write-enable would let a stray write corrupt a row.
  busy_enable_a: assert property ($rose(write_busy) |-> $past(write_enable_bit))
    else $error("Write start rose without write enable.");
  erase_start_a: assert property ($rose(erase_req) |-> write_busy && write_enable_bit)
    else $error("Erase began without a pending write start.");
  erase_align_a: assert property (erase_req |-> (erase_addr % EBLK) == 0)
    else $error("Erase address is off an erase block boundary.");
  erase_hold_a: assert property (
    erase_req && !erase_done |=> erase_req && $stable(erase_addr))
    else $error("Erase request dropped or moved before completion.");
  erase_end_a: assert property (
    erase_req && erase_done |=> !erase_req && !write_busy)
    else $error("Write start not cleared after erase completion.");
  prog_end_a: assert property ($fell(programming_clock) |-> ##[2:6] !prog_active)
    else $error("Programming did not end after the clock fell.");
  wdata_hold_a: assert property (
    flash_wvalid && !flash_wready |=> flash_wvalid && $stable(flash_wdata))
    else $error("Write word changed while stalled.");
  oe_rise_a: assert property ($rose(prog_data_oe) |-> programming_clock)
    else $error("Data pin driven outside a clock high phase.");
  dout_move_a: assert property (
    prog_data_oe && $changed(prog_data_out) |-> programming_clock)
    else $error("Read-back bit changed while the clock was low.");
endmodule

bind pfr_sequencer pfr_sequencer_sva #(.WBUF(WBUF), .EBLK(EBLK)) pfr_sequencer_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .programming_clock(programming_clock),
  .prog_data_in(prog_data_in), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
  .write_enable_bit(write_enable_bit), .write_busy(write_busy), .erase_req(erase_req),
  .erase_addr(erase_addr), .erase_done(erase_done), .prog_active(prog_active),
  .flash_wvalid(flash_wvalid), .flash_wdata(flash_wdata), .flash_wready(flash_wready));

//--- sim/pfr_prog_model.sv
// Behavioural serial programmer that clocks frames into the sequencer.
`timescale 1ns/1ps
module pfr_prog_model (
  output logic      programming_clock,
  output wire       line,
  input  wire logic dev_out,
  input  wire logic dev_oe
);
  logic drv = 1'b0;

  // The device owns the line while it drives; otherwise the programmer's bit shows.
  assign line = dev_oe ? dev_out : drv;
  initial programming_clock = 1'b0;

  // One frame: 4 command bits then 16 payload bits, LSB first, 160 ns per clock.
  task automatic xfer(input logic [3:0] cmd, input logic [15:0] pay, input int hold,
                      output logic [7:0] rd);
    logic [19:0] bits;
    bits = {pay, cmd};
    rd = 8'h00;
    #7;
    for (int i = 0; i < 20; i++) begin
      // Released during read-back, so toggle: a stale level can never pass.
      drv = (cmd == 4'h2 && i > 11) ? ~drv : bits[i];
      #40 programming_clock = 1'b1;
      // The fourth clock may be stretched to time the programming cycle.
      #(i == 3 ? 80 + hold : 80);
      if (i > 11) rd[i-12] = line;
      programming_clock = 1'b0;
      #40;
    end
    // Clock stays low afterwards so the array can discharge.
    #(40 + hold);
  endtask
endmodule

//--- sim/pfr_sequencer_tb.sv
// Self-checking bench for the program flash row modify sequencer.
`timescale 1ns/1ps
module pfr_sequencer_tb
  import pfr_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             erase_done = 1'b0;
  logic             flash_wready = 1'b0;
  logic             stall = 1'b1;
  wire              programming_clock;
  wire              line;
  logic             dout, doe, wen, busy, ereq, pact, wvalid;
  logic [PTR_W-1:0] eaddr;
  logic [PTR_W+7:0] wdata;
  logic [PTR_W+7:0] wq [$];
  logic [7:0]       bexp [16];
  int               err_total = 0;
  int               compares = 0;
  int               seed = 99048;
  int               cyc = 0;

  pfr_sequencer pfr_sequencer_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .programming_clock(programming_clock), .prog_data_in(line),
    .prog_data_out(dout), .prog_data_oe(doe),
    .write_enable_bit(wen), .write_busy(busy), .erase_req(ereq), .erase_addr(eaddr),
    .erase_done(erase_done), .prog_active(pact), .flash_wvalid(wvalid),
    .flash_wdata(wdata), .flash_wready(flash_wready));
  pfr_prog_model pfr_prog_model_inst (.programming_clock(programming_clock), .line(line),
    .dev_out(dout), .dev_oe(doe));

  // System clock at 100 MHz.
  initial forever #5 clk_sys = ~clk_sys;

  // The array stalls at random, and fully from the start of a row until mid-programming so the FIFO fills.
  always @(posedge clk_sys) begin
    #1;
    flash_wready = !stall && ($random(seed) % 3 != 0);
  end

  // Values seen at the falling edge are the ones the next rising edge takes.
  always @(negedge clk_sys) begin
    if (!rst && wvalid === 1'b1 && flash_wready === 1'b1) begin
      check("drain_word", wdata, wq.size() > 0 ? wq.pop_front() : '1);
    end
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [PTR_W+7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic core(input logic [15:0] p);
    logic [7:0] rd;
    pfr_prog_model_inst.xfer(CMD_CORE, p, 0, rd);
  endtask

  task automatic setp(input logic [PTR_W-1:0] a);
    core({OP_MOVLW, 2'b00, a[21:16]});
    core({OP_MOVWF, ADDR_PTR_UP});
    core({OP_MOVLW, a[15:8]});
    core({OP_MOVWF, ADDR_PTR_HI});
    core({OP_MOVLW, a[7:0]});
    core({OP_MOVWF, ADDR_PTR_LO});
  endtask

  task automatic poll(input logic [7:0] exp);
    logic [7:0] rd;
    core({OP_MOVF, ADDR_FCTRL});
    core({OP_MOVWF, ADDR_TLAT});
    core(OP_NOP);
    pfr_prog_model_inst.xfer(CMD_SHIFT_OUT, 16'h0000, 0, rd);
    check("poll_value", rd, exp);
  endtask

  // Load n pairs and the final pair; bexp is the programmer's copy of the row.
  task automatic row(input logic [PTR_W-1:0] base, input int n);
    logic [15:0]      d;
    logic [7:0]       rd;
    logic [PTR_W-1:0] tp;
    tp = base;
    stall = 1'b1;
    foreach (bexp[i]) bexp[i] = ERASED_BYTE;
    setp(base);
    for (int k = 0; k <= n; k++) begin
      d = 16'($random(seed));
      bexp[tp[3:0]] = d[7:0];
      bexp[tp[3:0] + 4'h1] = d[15:8];
      pfr_prog_model_inst.xfer(k == n ? CMD_LOAD_PROG : CMD_LOAD_INC2, d, 0, rd);
      tp = tp + PTR_INC;
    end
    for (int i = 0; i < 16; i++) wq.push_back({base[21:4], i[3:0], bexp[i]});
    fork
      pfr_prog_model_inst.xfer(CMD_CORE, OP_NOP, 3000, rd);
      begin
        #1500;
        check("prog_on", pact, 1'b1);
        stall = 1'b0;
      end
    join
    check("prog_off", pact, 1'b0);
    for (int t = 0; t < 400 && wq.size() > 0; t++) @(posedge clk_sys);
    check("drain_left", wq.size(), 0);
    $display("row %h with %0d loads done", base, n);
  endtask

  // Main sequence: refusal, row erase with polling, then two row writes.
  initial begin
    logic [PTR_W-1:0] base;
    logic [7:0]       rd;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check("busy_rst", busy, 1'b0);
    core(16'h8EA6);
    core(16'h9CA6);
    pfr_prog_model_inst.xfer(4'h5, 16'h82A6, 0, rd);
    core(16'h82A6);
    core(OP_NOP);
    core(OP_NOP);
    check("busy_no_write_enable_bit", busy, 1'b0);
    check("erase_no_write_enable_bit", ereq, 1'b0);
    poll(8'h80);
    $display("write start refusal done");
    base = PTR_W'($random(seed));
    base[3:0] = 4'h4;
    setp(base);
    core(16'h84A6);
    core(16'h88A6);
    core(16'h82A6);
    check("write_enable_bit_set", wen, 1'b1);
    check("busy_set", busy, 1'b1);
    core(OP_NOP);
    check("erase_early", ereq, 1'b0);
    core(OP_NOP);
    check("erase_on", ereq, 1'b1);
    check("erase_base", eaddr, {base[21:6], 6'h00});
    poll(8'h96);
    @(posedge clk_sys);
    #1 erase_done = 1'b1;
    @(posedge clk_sys);
    #1 erase_done = 1'b0;
    poll(8'h94);
    $display("row erase done");
    row(base, 5);
    row({base[21:6], base[5:4] ^ 2'b01, 4'h0}, 0);
    core(16'h94A6);
    check("write_enable_bit_clear", wen, 1'b0);
    report_and_stop();
  end
endmodule
